// >>> sew_pkg.sv
// Purpose: Shared constants and types of the presence-detect EEPROM slave
// Assumes: 100 MHz system clock, bus pins sampled by that clock
// Notes:   Every number used by more than one file lives here
package sew_pkg;

  // Clock and programming time
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PROG_TIME_MS  = 10;
  localparam int unsigned PROG_CYCLES   =
    (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned PROG_CNT_W    = 20;

  // Slave address fields
  localparam logic [3:0] TYPE_ARRAY = 4'ha;
  localparam logic [3:0] TYPE_WPREG = 4'h6;
  localparam logic       DIR_READ   = 1'h1;

  // Byte framing
  localparam logic [3:0] BIT_LAST   = 4'h8;
  localparam logic [3:0] BIT_FIRST  = 4'h0;

  // Array geometry and protection
  localparam int unsigned ARRAY_BYTES = 256;
  localparam int unsigned PAGE_BYTES  = 16;
  localparam int unsigned FIFO_DEPTH  = 8;
  localparam logic [7:0]  PROT_LIMIT  = 8'h80;

  // Reset values
  localparam logic [7:0]  ERASED_BYTE = 8'hff;
  localparam logic [7:0]  ADDR_RST    = 8'h00;
  localparam logic [15:0] MASK_RST    = 16'h0000;
  localparam logic [5:0]  PINS_RST    = 6'h03;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK
  } sew_state_t;

  typedef enum logic [1:0] {
    K_SLAVE,
    K_BADDR,
    K_DATA
  } sew_kind_t;

endpackage

// >>> sew_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are quasi-static against the sampling clock
// Notes:   The first stage feeds only the second stage
`timescale 1ns/1ps
module sew_sync #(
  parameter int unsigned      WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             srst_in,
  // Pins and their synchronised copies
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

// >>> sew_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Flush drops the contents in one cycle
`timescale 1ns/1ps
module sew_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             srst_in,
  input  wire logic             flush_in,
  // Fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Drain side
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  wire              push = in_valid_in && in_ready_out;
  wire              pop  = out_valid_out && out_ready_in;

  assign in_ready_out  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign out_data_out  = mem_r[rd_ptr_r];

  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in || flush_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      wr_ptr_r <= push ? wr_ptr_r + 1'b1 : wr_ptr_r;
      rd_ptr_r <= pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
      count_r  <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// >>> sew_top.sv
// Purpose: Two-wire slave front end of a 2K-bit presence-detect EEPROM
// Assumes: SCL and SDA arrive as pins, oversampled by mclk_in
// Notes:   SDA is open drain; the pin is pulled low while sda_oe_out is high
//
// Notes on behaviour
// - SDA rising while SCL high is a stop; it ends any transfer.
// - Stop with nothing to program returns to idle, waiting for start.
// - Transmitter frees SDA after eight bits; receiver pulls ninth low.
// - A matching slave address after start is acknowledged.
// - Selected for write, every later byte is acknowledged unless blocked.
// - Reads send eight bits, sample ack, and continue on ack.
// - Missing master ack: stop driving and wait for stop.
// - Address upper nibble is device type; array answers only to 1010.
// - Three chip-select bits must equal the straps, else ignore.
// - Address bit zero: one reads, zero writes.
// - A write carries an eight-bit byte address, acknowledged.
// - Stop after an acknowledged data byte starts self-timed programming.
// - While programming, all bus traffic is ignored and never acked.
// - Page writes of up to sixteen bytes are accepted and acked.
// - Write address steps per byte and wraps inside the sixteen-byte page; reads cross pages.
// - Polling with a write address: no ack while busy, ack after.
// - Once locked, the lower 128 bytes are never programmed.
// - Lock register sets once; later accesses are ignored.
// - Lock register uses type 0110 byte write; 1010 stays for array.
// - SDA falling while SCL high is a start; nothing before it.
// - SDA changes while SCL low; data sampled while SCL high.
// - Protect pin high: first data byte not acked, nothing programmed.
`timescale 1ns/1ps
module sew_top #(
  parameter int unsigned PROG_CYCLES = sew_pkg::PROG_CYCLES
) (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic srst_in,
  // Two-wire bus
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out_out,
  output logic      sda_oe_out,
  // Straps and protect pin
  input  wire logic chip_select_strap_bit0_in,
  input  wire logic chip_select_strap_bit1_in,
  input  wire logic chip_select_strap_bit2_in,
  input  wire logic hw_protect_in,
  // Status
  output logic      busy_out,
  output logic      wp_locked_out
);

  localparam int unsigned PW = sew_pkg::PROG_CNT_W;
  localparam logic [PW-1:0] PROG_LAST = PW'(PROG_CYCLES - 1);

  sew_pkg::sew_state_t state_r;
  sew_pkg::sew_kind_t  kind_r;

  logic [5:0]    pins_s;
  logic          scl_d_r;
  logic          sda_d_r;
  logic [7:0]    shift_r;
  logic [3:0]    cnt_r;
  logic          sda_oe_r;
  logic          sda_lvl_r;
  logic          ack_r;
  logic          rw_r;
  logic          wpreg_r;
  logic          mack_r;
  logic [7:0]    addr_r;
  logic [7:0]    page_r [sew_pkg::PAGE_BYTES];
  logic [15:0]   mask_r;
  logic          pend_r;
  logic          pend_wp_r;
  logic          busy_r;
  logic [PW-1:0] prog_cnt_r;
  logic          wp_locked_r;
  logic [7:0]    mem_r [sew_pkg::ARRAY_BYTES];
  logic          pf_on_r;
  logic [7:0]    pf_addr_r;
  logic          fifo_ready;
  logic          fifo_valid;
  logic [7:0]    fifo_data;

  // Pins pass two flops before any decoding
  sew_sync #(
    .WIDTH   (6),
    .RST_VAL (sew_pkg::PINS_RST)
  ) u_sync (
    .mclk_in  (mclk_in),
    .srst_in  (srst_in),
    .async_in ({hw_protect_in, chip_select_strap_bit2_in,
                chip_select_strap_bit1_in, chip_select_strap_bit0_in,
                sda_in, scl_in}),
    .sync_out (pins_s)
  );

  wire       scl_s    = pins_s[0];
  wire       sda_s    = pins_s[1];
  wire [2:0] strap_s  = pins_s[4:2];
  wire       hw_wp_s  = pins_s[5];

  // Bus events
  wire scl_rise  = scl_s && !scl_d_r;
  wire scl_fall  = !scl_s && scl_d_r;
  wire start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
  wire stop_det  = scl_s && scl_d_r && !sda_d_r && sda_s;
  wire fsm_go    = !busy_r && !stop_det && !start_det;

  // Byte decode at the falling edge that closes bit eight
  wire byte_done = fsm_go && scl_fall && state_r == sew_pkg::ST_RX &&
                   cnt_r == sew_pkg::BIT_LAST;
  wire type_arr  = shift_r[7:4] == sew_pkg::TYPE_ARRAY;
  // Locked register behaves as an absent device
  wire type_wp   = shift_r[7:4] == sew_pkg::TYPE_WPREG &&
                   shift_r[0] != sew_pkg::DIR_READ &&
                   !wp_locked_r;
  wire slave_hit = (type_arr || type_wp) &&
                   shift_r[3:1] == strap_s;
  wire low_lock  = wp_locked_r && addr_r < sew_pkg::PROT_LIMIT;
  wire blocked   = hw_wp_s || (!wpreg_r && low_lock);
  wire ack_now   = kind_r == sew_pkg::K_SLAVE ? slave_hit :
                   kind_r == sew_pkg::K_BADDR ? 1'b1 : !blocked;
  wire slave_ok  = byte_done && kind_r == sew_pkg::K_SLAVE && slave_hit;
  wire baddr_ok  = byte_done && kind_r == sew_pkg::K_BADDR;
  wire data_ok   = byte_done && kind_r == sew_pkg::K_DATA && !blocked;
  wire rd_start  = slave_ok && shift_r[0] == sew_pkg::DIR_READ;
  wire ack_end   = fsm_go && scl_fall && state_r == sew_pkg::ST_ACK;
  wire tx_first  = ack_end && ack_r && rw_r &&
                   kind_r == sew_pkg::K_SLAVE;
  wire tx_next   = fsm_go && scl_fall && state_r == sew_pkg::ST_MACK &&
                   mack_r;
  wire tx_load   = tx_first || tx_next;
  wire [7:0] tx_byte = fifo_valid ? fifo_data : sew_pkg::ERASED_BYTE;
  wire prog_go   = stop_det && pend_r && !busy_r;
  wire prog_done = busy_r && prog_cnt_r == '0;
  wire fifo_flush = start_det || stop_det || rd_start;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // Bus state machine; drive changes on SCL falling edges, and start, stop or busy releases it
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_r  <= sew_pkg::ST_IDLE;
      kind_r   <= sew_pkg::K_SLAVE;
      shift_r  <= sew_pkg::ADDR_RST;
      cnt_r    <= sew_pkg::BIT_FIRST;
      sda_oe_r <= 1'b0;
      ack_r    <= 1'b0;
      rw_r     <= 1'b0;
      wpreg_r  <= 1'b0;
      mack_r   <= 1'b0;
    end else if (busy_r || stop_det) begin
      state_r  <= sew_pkg::ST_IDLE;
      sda_oe_r <= 1'b0;
    end else if (start_det) begin
      state_r  <= sew_pkg::ST_RX;
      kind_r   <= sew_pkg::K_SLAVE;
      cnt_r    <= sew_pkg::BIT_FIRST;
      sda_oe_r <= 1'b0;
    end else begin
      case (state_r)
        sew_pkg::ST_RX: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_s};
            cnt_r   <= cnt_r + 4'h1;
          end else if (byte_done) begin
            state_r  <= sew_pkg::ST_ACK;
            sda_oe_r <= ack_now;
            ack_r    <= ack_now;
            if (kind_r == sew_pkg::K_SLAVE) begin
              rw_r    <= shift_r[0];
              wpreg_r <= shift_r[7:4] == sew_pkg::TYPE_WPREG;
            end
          end
        end
        sew_pkg::ST_ACK: begin
          if (scl_fall) begin
            cnt_r <= sew_pkg::BIT_FIRST;
            if (!ack_r) begin
              state_r  <= sew_pkg::ST_IDLE;
              sda_oe_r <= 1'b0;
            end else if (tx_first) begin
              state_r  <= sew_pkg::ST_TX;
              shift_r  <= tx_byte;
              sda_oe_r <= !tx_byte[7];
            end else begin
              state_r  <= sew_pkg::ST_RX;
              sda_oe_r <= 1'b0;
              kind_r   <= kind_r == sew_pkg::K_SLAVE ?
                          sew_pkg::K_BADDR : sew_pkg::K_DATA;
            end
          end
        end
        sew_pkg::ST_TX: begin
          if (scl_rise) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == sew_pkg::BIT_LAST) begin
              state_r  <= sew_pkg::ST_MACK;
              sda_oe_r <= 1'b0;
            end else begin
              shift_r  <= {shift_r[6:0], 1'b0};
              sda_oe_r <= !shift_r[6];
            end
          end
        end
        sew_pkg::ST_MACK: begin
          if (scl_rise) begin
            mack_r <= !sda_s;
          end else if (tx_next) begin
            state_r  <= sew_pkg::ST_TX;
            cnt_r    <= sew_pkg::BIT_FIRST;
            shift_r  <= tx_byte;
            sda_oe_r <= !tx_byte[7];
          end else if (scl_fall) begin
            state_r  <= sew_pkg::ST_IDLE;
            sda_oe_r <= 1'b0;
          end
        end
        default: begin
          state_r  <= sew_pkg::ST_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // Address counter and page buffer
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      addr_r <= sew_pkg::ADDR_RST;
    end else if (baddr_ok && !wpreg_r) begin
      addr_r <= shift_r;
    end else if (data_ok && !wpreg_r) begin
      addr_r <= {addr_r[7:4], addr_r[3:0] + 4'h1};
    end else if (tx_load) begin
      addr_r <= addr_r + 8'h01;
    end
  end

  // Later bytes of an over-long page land on earlier slots
  always_ff @(posedge mclk_in) begin
    if (data_ok && !wpreg_r) begin
      page_r[addr_r[3:0]] <= shift_r;
    end
  end

  // Lock writes only need the data ack; their fields are ignored
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      mask_r    <= sew_pkg::MASK_RST;
      pend_r    <= 1'b0;
      pend_wp_r <= 1'b0;
    end else begin
      if (slave_ok) begin
        mask_r    <= sew_pkg::MASK_RST;
        pend_wp_r <= 1'b0;
      end else if (data_ok && !wpreg_r) begin
        mask_r[addr_r[3:0]] <= 1'b1;
      end else if (data_ok) begin
        pend_wp_r <= 1'b1;
      end
      if (data_ok) begin
        pend_r <= 1'b1;
      end else if (prog_go || (start_det && !busy_r)) begin
        pend_r <= 1'b0;
      end
    end
  end

  // Self-timed programming; bus logic is held idle meanwhile
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      busy_r     <= 1'b0;
      prog_cnt_r <= '0;
    end else if (prog_go) begin
      busy_r     <= 1'b1;
      prog_cnt_r <= PROG_LAST;
    end else if (prog_done) begin
      busy_r     <= 1'b0;
    end else if (busy_r) begin
      prog_cnt_r <= prog_cnt_r - PW'(1);
    end
  end

  // Lock is volatile here; a real array keeps it across power cycles
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wp_locked_r <= 1'b0;
    end else if (prog_done && pend_wp_r) begin
      wp_locked_r <= 1'b1;
    end
  end

  // Array commit at the end of the busy period
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      for (int i = 0; i < sew_pkg::ARRAY_BYTES; i++) begin
        mem_r[i] <= sew_pkg::ERASED_BYTE;
      end
    end else if (prog_done) begin
      for (int i = 0; i < sew_pkg::PAGE_BYTES; i++) begin
        if (mask_r[i]) begin
          mem_r[{addr_r[7:4], 4'(i)}] <= page_r[i];
        end
      end
    end
  end

  // Read prefetch keeps the FIFO ahead of the shifter
  always_ff @(posedge mclk_in) begin
    if (srst_in || start_det || stop_det || busy_r) begin
      pf_on_r   <= 1'b0;
      pf_addr_r <= sew_pkg::ADDR_RST;
    end else if (rd_start) begin
      pf_on_r   <= 1'b1;
      pf_addr_r <= addr_r;
    end else if (pf_on_r && fifo_ready) begin
      pf_addr_r <= pf_addr_r + 8'h01;
    end
  end

  sew_fifo #(
    .WIDTH (8),
    .DEPTH (sew_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_in       (mclk_in),
    .srst_in       (srst_in),
    .flush_in      (fifo_flush),
    .in_valid_in   (pf_on_r),
    .in_data_in    (mem_r[pf_addr_r]),
    .in_ready_out  (fifo_ready),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_data),
    .out_ready_in  (tx_load)
  );

  always_ff @(posedge mclk_in) begin
    sda_lvl_r <= 1'b0;
  end

  assign sda_out_out   = sda_lvl_r;
  assign sda_oe_out    = sda_oe_r;
  assign busy_out      = busy_r;
  assign wp_locked_out = wp_locked_r;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  chk_stop_idle: assert property (
    (stop_det && !busy_r) |=> state_r == sew_pkg::ST_IDLE && !sda_oe_r)
    else $error("stop did not return to idle");

  chk_busy_silent: assert property (
    busy_r |=> !sda_oe_r)
    else $error("bus driven during programming");

  chk_prog_start: assert property (
    prog_go |=> busy_r && prog_cnt_r == PROG_LAST)
    else $error("programming not started at stop");

  chk_type_nack: assert property (
    (byte_done && kind_r == sew_pkg::K_SLAVE && !type_arr && !type_wp)
    |=> !sda_oe_r [*2])
    else $error("foreign device type acknowledged");

  chk_addr_ack: assert property (
    slave_ok |=> sda_oe_r && state_r == sew_pkg::ST_ACK)
    else $error("matching address not acknowledged");

  chk_protect_nack: assert property (
    (byte_done && kind_r == sew_pkg::K_DATA && blocked)
    |=> !sda_oe_r && !pend_r)
    else $error("protected data acknowledged");

  chk_page_wrap: assert property (
    (data_ok && !wpreg_r) |=> addr_r[7:4] == $past(addr_r[7:4]) &&
    addr_r[3:0] == $past(addr_r[3:0]) + 4'h1)
    else $error("address left the page");

  chk_lock_held: assert property (
    wp_locked_r |=> wp_locked_r)
    else $error("lock register cleared");

  chk_nack_release: assert property (
    (fsm_go && scl_fall && state_r == sew_pkg::ST_MACK && !mack_r)
    |=> state_r == sew_pkg::ST_IDLE && !sda_oe_r)
    else $error("transmission continued after no ack");

  chk_rx_released: assert property (
    state_r == sew_pkg::ST_RX |-> !sda_oe_r)
    else $error("data line driven while receiving");

endmodule

// >>> sew_master.sv
// Purpose: Bit-level two-wire bus master that drives SCL and SDA
// Assumes: SDA has a pull-up, so a line that nobody pulls reads high
// Notes:   The SCL period is 13 mclk (130 ns). It is the nearest fit to
//          125 ns that keeps 50 ns of setup and hold at each SCL edge.
`timescale 1ns/1ps
module sew_master (
  // Clock
  input  wire logic mclk_in,
  // Bus
  input  wire logic sda_line_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  initial begin
    scl_out     = 1'h1;
    sda_low_out = 1'h0;
  end

  task automatic w(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  // One SCL pulse; SDA moves only while SCL is low
  task automatic bit_clk(input logic low, output logic seen);
    w(5);
    sda_low_out <= low;
    w(5);
    scl_out <= 1'h1;
    w(3);
    seen = sda_line_in;
    scl_out <= 1'h0;
  endtask

  // Start or repeated start; leaves SCL low
  task automatic start();
    w(5);
    sda_low_out <= 1'h0;
    w(5);
    scl_out <= 1'h1;
    w(5);
    sda_low_out <= 1'h1;
    w(5);
    scl_out <= 1'h0;
  endtask

  // SCL then stands high until the next start
  task automatic stop();
    w(5);
    sda_low_out <= 1'h1;
    w(5);
    scl_out <= 1'h1;
    w(5);
    sda_low_out <= 1'h0;
    w(5);
  endtask

  // Lowers SCL from idle without making a start
  task automatic idle_low();
    w(5);
    scl_out <= 1'h0;
  endtask

  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_clk(~b[i], s);
    end
    bit_clk(1'h0, s);
    ack = ~s;
  endtask

  task automatic get(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_clk(1'h0, s);
      b[i] = s;
    end
    bit_clk(ack, s);
  endtask
endmodule

// >>> tb_top.sv
// Purpose: Self-checking bench of the presence-detect EEPROM slave
// Assumes: Programming time shortened to 200 mclk
// Notes:   Table rows cover plain writes; page, abort and reset follow
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned PROG  = 200;
  localparam logic [2:0]  STRAP = 3'h5;
  localparam logic [7:0]  SA_W  = {sew_pkg::TYPE_ARRAY, STRAP, 1'h0};
  localparam logic [7:0]  SA_R  = {sew_pkg::TYPE_ARRAY, STRAP, 1'h1};
  localparam logic [7:0]  SA_L  = {sew_pkg::TYPE_WPREG, STRAP, 1'h0};

  typedef struct packed {
    logic [7:0] sa;
    logic [7:0] ba;
    logic [7:0] d;
    logic       hwp;
    logic       a_sa;
    logic       a_d;
    logic [7:0] rd;
    logic       lk;
  } sew_row_t;

  localparam sew_row_t ROWS [10] = '{
    '{SA_W,  8'h10, 8'h5a, 1'h0, 1'h1, 1'h1, 8'h5a, 1'h0},
    '{8'ha4, 8'h10, 8'h33, 1'h0, 1'h0, 1'h0, 8'h5a, 1'h0},
    '{8'h5a, 8'h20, 8'h33, 1'h0, 1'h0, 1'h0, 8'hff, 1'h0},
    '{SA_W,  8'h90, 8'h11, 1'h1, 1'h1, 1'h0, 8'hff, 1'h0},
    '{SA_L,  8'h00, 8'h00, 1'h1, 1'h1, 1'h0, 8'hff, 1'h0},
    '{SA_W,  8'h90, 8'h22, 1'h0, 1'h1, 1'h1, 8'h22, 1'h0},
    '{SA_L,  8'h90, 8'h00, 1'h0, 1'h1, 1'h1, 8'h22, 1'h1},
    '{SA_W,  8'h10, 8'h77, 1'h0, 1'h1, 1'h0, 8'h5a, 1'h1},
    '{SA_W,  8'h90, 8'h33, 1'h0, 1'h1, 1'h1, 8'h33, 1'h1},
    '{SA_L,  8'h00, 8'h00, 1'h0, 1'h0, 1'h0, 8'hff, 1'h1}
  };

  logic       mclk_in;
  logic       srst_in;
  logic       hw_protect;
  logic [2:0] strap;
  logic       scl;
  logic       sda_low;
  logic       sda_line;
  logic       sda_out;
  logic       sda_oe;
  logic       busy;
  logic       locked;
  int         n_fail = 0;
  int         checks_done = 0;

  // Open-drain wire with its pull-up
  assign sda_line = ~(sda_low | sda_oe);

  sew_top #(.PROG_CYCLES(PROG)) uut (
    .mclk_in                   (mclk_in),
    .srst_in                   (srst_in),
    .scl_in                    (scl),
    .sda_in                    (sda_line),
    .sda_out_out               (sda_out),
    .sda_oe_out                (sda_oe),
    .chip_select_strap_bit0_in (strap[0]),
    .chip_select_strap_bit1_in (strap[1]),
    .chip_select_strap_bit2_in (strap[2]),
    .hw_protect_in             (hw_protect),
    .busy_out                  (busy),
    .wp_locked_out             (locked)
  );

  sew_master master (
    .mclk_in     (mclk_in),
    .sda_line_in (sda_line),
    .scl_out     (scl),
    .sda_low_out (sda_low)
  );

  initial begin
    mclk_in = 1'h0;
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic end_of_test();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Ack polling until the self-timed write ends
  task automatic poll();
    logic ack;
    master.w(3);
    chk(busy, 1'h1);
    master.start();
    master.put(SA_W, ack);
    chk(ack, 1'h0);
    master.stop();
    for (int i = 0; i < 20 && ack !== 1'h1; i++) begin
      master.start();
      master.put(SA_W, ack);
      master.stop();
    end
    chk(ack, 1'h1);
    chk(busy, 1'h0);
  endtask

  // Random read of n bytes; the last one is not acknowledged
  task automatic rd_at(input logic [7:0] ba, input int n,
                       output logic [7:0] q [$]);
    logic       ack;
    logic [7:0] b;
    q = {};
    master.start();
    master.put(SA_W, ack);
    master.put(ba, ack);
    master.start();
    master.put(SA_R, ack);
    for (int i = 0; i < n; i++) begin
      master.get(i < n - 1, b);
      q.push_back(b);
    end
    master.w(8);
    chk(sda_oe, 1'h0);
    master.stop();
  endtask

  task automatic run_row(input sew_row_t r);
    logic       ack;
    logic [7:0] q [$];
    hw_protect <= r.hwp;
    master.start();
    master.put(r.sa, ack);
    chk(ack, r.a_sa);
    if (r.a_sa) begin
      master.put(r.ba, ack);
      chk(ack, 1'h1);
      master.put(r.d, ack);
      chk(ack, r.a_d);
    end
    master.stop();
    if (r.a_d) begin
      poll();
    end
    chk(locked, r.lk);
    hw_protect <= 1'h0;
    rd_at(r.ba, 1, q);
    chk(q[0], r.rd);
  endtask

  initial begin
    logic       ack;
    logic [7:0] q [$];
    srst_in    = 1'h1;
    hw_protect = 1'h0;
    strap      = STRAP;
    repeat (5) @(posedge mclk_in);
    srst_in <= 1'h0;
    master.w(10);
    chk({busy, locked, sda_oe, sda_out}, 8'h00);
    foreach (ROWS[i]) begin
      run_row(ROWS[i]);
    end
    // Eighteen bytes into one page: the last two land on the first two
    master.start();
    master.put(SA_W, ack);
    master.put(8'ha0, ack);
    for (int i = 0; i < 18; i++) begin
      master.put(8'h40 + 8'(i), ack);
      chk(ack, 1'h1);
    end
    master.stop();
    poll();
    rd_at(8'ha0, 15, q);
    for (int j = 0; j < 15; j++) begin
      chk(q[j], 8'h40 + 8'(j < 2 ? j + 16 : j));
    end
    // Stop before any data byte leaves nothing to program
    master.start();
    master.put(SA_W, ack);
    master.put(8'h30, ack);
    master.stop();
    master.w(10);
    chk(busy, 1'h0);
    // A byte clocked without a start is ignored
    master.idle_low();
    master.put(SA_W, ack);
    chk(ack, 1'h0);
    master.stop();
    // Moved straps: the old address is ignored, the new one answered
    strap <= 3'h2;
    master.w(10);
    master.start();
    master.put(SA_W, ack);
    chk(ack, 1'h0);
    master.stop();
    master.start();
    master.put({sew_pkg::TYPE_ARRAY, 3'h2, 1'h0}, ack);
    chk(ack, 1'h1);
    master.stop();
    strap <= STRAP;
    // Mid-run reset clears the lock and the array
    srst_in <= 1'h1;
    master.w(5);
    srst_in <= 1'h0;
    master.w(10);
    chk(locked, 1'h0);
    rd_at(8'h90, 1, q);
    chk(q[0], sew_pkg::ERASED_BYTE);
    end_of_test();
  end

  // Cut short a hang well past the expected run length
  initial begin
    repeat (90000) @(posedge mclk_in);
    n_fail++;
    end_of_test();
  end
endmodule
